/* include/apms_pkg.sv */
// Package with register map, field layout and constants of the angle PLL mode-switch block
package apms_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int POS_W = 24;
    localparam int SYN_W = 10;
    // Register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_STATE_STORED = 8'h08;
    localparam logic [7:0] OFS_TRIG_STORED = 8'h0C;
    localparam logic [7:0] OFS_STATE_CORR = 8'h10;
    localparam logic [7:0] OFS_TRIG_CORR = 8'h14;
    localparam logic [7:0] OFS_INC_CNT = 8'h18;
    localparam logic [7:0] OFS_STATE_TARGET = 8'h1C;
    localparam logic [7:0] OFS_TRIG_TARGET = 8'h20;
    localparam logic [7:0] OFS_TRIG_TOOTH = 8'h24;
    localparam logic [7:0] OFS_STATE_TOOTH = 8'h28;
    // Control register bit positions
    localparam int CTRL_PLL_ENABLE = 0;
    localparam int CTRL_EMERGENCY = 1;
    localparam int CTRL_STATE_IN_EN = 2;
    localparam int CTRL_TRIG_IN_EN = 3;
    localparam int CTRL_BACKWARD = 4;
    // Status register bit positions
    localparam int STAT_LOCK = 0;
    localparam int STAT_MODE_SHADOW = 1;
    localparam int STAT_MISSING = 2;
    localparam int STAT_GAP_LSB = 4;
    // Tooth count register layout: sync factor, old sync factor, write enable
    localparam int TOOTH_SYN_LSB = 0;
    localparam int TOOTH_OLD_LSB = 10;
    localparam int TOOTH_SYNC_WRITE_ENABLE = 31;
    // Gaps needed to raise the lock flag again after a direction change
    localparam logic [2:0] RELOCK_GAPS = 3'h2;
    localparam logic [31:0] RESET_ZERO = 32'h00000000;
endpackage

/* rtl/apms_mode_switch.sv */
// Mode-switch, lock and sync-factor logic of the angle PLL
//
// Local design decisions: strobed register access and the register addresses.
`timescale 1ns/1ps
module apms_mode_switch #(
    parameter int POS_W = apms_pkg::POS_W
) (
    input wire logic clock,
    input wire logic srst,
    input wire logic [apms_pkg::ADDR_W-1:0] addr,
    input wire logic [apms_pkg::DATA_W-1:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [apms_pkg::DATA_W-1:0] rdata,
    input wire logic state_slope_pin,
    input wire logic trigger_slope_pin,
    input wire logic missing_state_pin,
    input wire logic direction_change_pin,
    output logic first_lock_flag,
    output logic [POS_W-1:0] state_position_corrected,
    output logic [POS_W-1:0] trigger_position_corrected
);
    // Widths beyond the data word cannot be reached over the register port
    if (POS_W < 2 || POS_W > apms_pkg::DATA_W) begin
        $error("POS_W must lie between 2 and the data width");
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers; events come from another domain
    logic [3:0] sync1;
    logic [3:0] sync2;
    logic [3:0] sync3;
    always_ff @(posedge clock) begin
        if (srst) begin
            sync1 <= 4'h0;
            sync2 <= 4'h0;
            sync3 <= 4'h0;
        end else begin
            sync1 <= {direction_change_pin, missing_state_pin, trigger_slope_pin,
                      state_slope_pin};
            sync2 <= sync1;
            sync3 <= sync2;
        end
    end
    // Rising edges of the second stage only
    logic state_ev, trig_ev, miss_ev, dir_ev;
    assign state_ev = sync2[0] & ~sync3[0];
    assign trig_ev = sync2[1] & ~sync3[1];
    assign miss_ev = sync2[2] & ~sync3[2];
    assign dir_ev = sync2[3] & ~sync3[3];

    ////////////////////////////////////////////////////////////////////////
    // Control register
    logic pll_enable_bit, emergency_mode_select, state_input_enable;
    logic trigger_input_enable, backward;
    logic wr_ctrl;
    assign wr_ctrl = wr && addr == apms_pkg::OFS_CTRL;
    always_ff @(posedge clock) begin
        if (srst) begin
            pll_enable_bit <= 1'b0;
            emergency_mode_select <= 1'b0;
            state_input_enable <= 1'b0;
            trigger_input_enable <= 1'b0;
            backward <= 1'b0;
        end else if (wr_ctrl) begin
            pll_enable_bit <= wdata[apms_pkg::CTRL_PLL_ENABLE];
            emergency_mode_select <= wdata[apms_pkg::CTRL_EMERGENCY];
            state_input_enable <= wdata[apms_pkg::CTRL_STATE_IN_EN];
            trigger_input_enable <= wdata[apms_pkg::CTRL_TRIG_IN_EN];
            backward <= wdata[apms_pkg::CTRL_BACKWARD];
        end
    end

    // Active events only count when their input is enabled
    logic act_state, act_trig;
    assign act_state = state_ev & state_input_enable;
    assign act_trig = trig_ev & trigger_input_enable;

    ////////////////////////////////////////////////////////////////////////
    // Stored counts, increment count and pulse targets, all software-loaded
    logic [POS_W-1:0] state_position_stored, trigger_position_stored;
    logic [POS_W-1:0] pulse_increment_count, state_target, trig_target;
    always_ff @(posedge clock) begin
        if (srst) begin
            state_position_stored <= '0;
            trigger_position_stored <= '0;
            pulse_increment_count <= '0;
            state_target <= '0;
            trig_target <= '0;
        end else if (wr) begin
            if (addr == apms_pkg::OFS_STATE_STORED) begin
                state_position_stored <= wdata[POS_W-1:0];
            end else if (addr == apms_pkg::OFS_TRIG_STORED) begin
                trigger_position_stored <= wdata[POS_W-1:0];
            end else if (addr == apms_pkg::OFS_INC_CNT) begin
                pulse_increment_count <= wdata[POS_W-1:0];
            end else if (addr == apms_pkg::OFS_STATE_TARGET) begin
                state_target <= wdata[POS_W-1:0];
            end else if (addr == apms_pkg::OFS_TRIG_TARGET) begin
                trig_target <= wdata[POS_W-1:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Mode shadow and pending transition tracking
    logic mode_shadow;
    logic was_enabled;
    logic pend_to_emerg, pend_to_norm, pend_start;
    logic capture;
    // Shadow only follows the request on active events while enabled
    assign capture = pll_enable_bit & (act_state | act_trig);
    always_ff @(posedge clock) begin
        if (srst) begin
            mode_shadow <= 1'b0;
            was_enabled <= 1'b0;
        end else begin
            was_enabled <= pll_enable_bit;
            if (capture) begin
                mode_shadow <= emergency_mode_select;
            end
        end
    end

    // Corrections due on the slope that follows a captured mode change
    always_ff @(posedge clock) begin
        if (srst) begin
            pend_to_emerg <= 1'b0;
            pend_to_norm <= 1'b0;
            pend_start <= 1'b0;
        end else if (!pll_enable_bit) begin
            pend_to_emerg <= 1'b0;
            pend_to_norm <= 1'b0;
            pend_start <= 1'b0;
        end else begin
            // Enable edge: first event only copies the stored count
            if (!was_enabled) begin
                pend_start <= 1'b1;
            end else if (capture) begin
                pend_start <= 1'b0;
            end
            // Cleared once served so later slopes leave the count alone
            if (capture && was_enabled && !pend_start &&
                emergency_mode_select && !mode_shadow) begin
                pend_to_emerg <= 1'b1;
            end else if (act_state) begin
                pend_to_emerg <= 1'b0;
            end
            if (capture && was_enabled && !pend_start &&
                !emergency_mode_select && mode_shadow) begin
                pend_to_norm <= 1'b1;
            end else if (act_trig) begin
                pend_to_norm <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Corrected position counts
    logic [POS_W-1:0] state_corr_value, trig_corr_value;
    assign state_corr_value = pulse_increment_count - state_target;
    assign trig_corr_value = pulse_increment_count - trig_target;
    logic [POS_W-1:0] next_state_corr, next_trig_corr;
    // Forward adds, backward subtracts
    assign next_state_corr = backward ? state_position_stored - state_corr_value
                                      : state_position_stored + state_corr_value;
    assign next_trig_corr = backward ? trigger_position_stored - trig_corr_value
                                     : trigger_position_stored + trig_corr_value;
    always_ff @(posedge clock) begin
        if (srst) begin
            state_position_corrected <= '0;
        end else if (wr && addr == apms_pkg::OFS_STATE_CORR) begin
            state_position_corrected <= wdata[POS_W-1:0];
        end else if (pend_start && act_state && emergency_mode_select) begin
            state_position_corrected <= state_position_stored;
        end else if (pend_to_emerg && act_state) begin
            state_position_corrected <= next_state_corr;
        end
    end
    always_ff @(posedge clock) begin
        if (srst) begin
            trigger_position_corrected <= '0;
        end else if (wr && addr == apms_pkg::OFS_TRIG_CORR) begin
            trigger_position_corrected <= wdata[POS_W-1:0];
        end else if (pend_start && act_trig && !emergency_mode_select) begin
            trigger_position_corrected <= trigger_position_stored;
        end else if (pend_to_norm && act_trig) begin
            trigger_position_corrected <= next_trig_corr;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Lock flag: cleared on direction change in emergency, relocked by gaps
    logic [2:0] gap_count;
    logic missing_state_flag;
    logic relocking;
    always_ff @(posedge clock) begin
        if (srst) begin
            first_lock_flag <= 1'b0;
            gap_count <= 3'h0;
            relocking <= 1'b0;
        end else if (mode_shadow && dir_ev) begin
            first_lock_flag <= 1'b0;
            gap_count <= 3'h0;
            relocking <= 1'b1;
        end else if (relocking && miss_ev) begin
            // Intended count of two, not the four of older silicon
            if (gap_count + 3'h1 >= apms_pkg::RELOCK_GAPS) begin
                first_lock_flag <= 1'b1;
                relocking <= 1'b0;
                gap_count <= 3'h0;
            end else begin
                gap_count <= gap_count + 3'h1;
            end
        end else if (relocking && act_state) begin
            gap_count <= 3'h0; // Gaps must be consecutive
        end else if (!relocking && pll_enable_bit && act_state) begin
            first_lock_flag <= 1'b1;
        end
    end
    // Missing state flag: set wins over a clear write of ones
    always_ff @(posedge clock) begin
        if (srst) begin
            missing_state_flag <= 1'b0;
        end else if (miss_ev) begin
            missing_state_flag <= 1'b1;
        end else if (wr && addr == apms_pkg::OFS_STATUS && wdata[apms_pkg::STAT_MISSING]) begin
            missing_state_flag <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Tooth count registers: sync factor and old sync factor
    logic [apms_pkg::SYN_W-1:0] trig_syn, trig_syn_old, state_syn, state_syn_old;
    always_ff @(posedge clock) begin
        if (srst) begin
            trig_syn <= '0;
            trig_syn_old <= '0;
            state_syn <= '0;
            state_syn_old <= '0;
        end else if (wr && wdata[apms_pkg::TOOTH_SYNC_WRITE_ENABLE]) begin
            // Old field takes the written bits, not the previous factor
            if (addr == apms_pkg::OFS_TRIG_TOOTH) begin
                trig_syn <= wdata[apms_pkg::TOOTH_SYN_LSB +: apms_pkg::SYN_W];
                trig_syn_old <= wdata[apms_pkg::TOOTH_OLD_LSB +: apms_pkg::SYN_W];
            end else if (addr == apms_pkg::OFS_STATE_TOOTH) begin
                state_syn <= wdata[apms_pkg::TOOTH_SYN_LSB +: apms_pkg::SYN_W];
                state_syn_old <= wdata[apms_pkg::TOOTH_OLD_LSB +: apms_pkg::SYN_W];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read mux; unmapped addresses read zero
    logic [apms_pkg::DATA_W-1:0] next_rdata;
    always_comb begin
        next_rdata = apms_pkg::RESET_ZERO;
        if (addr == apms_pkg::OFS_CTRL) begin
            next_rdata[apms_pkg::CTRL_PLL_ENABLE] = pll_enable_bit;
            next_rdata[apms_pkg::CTRL_EMERGENCY] = emergency_mode_select;
            next_rdata[apms_pkg::CTRL_STATE_IN_EN] = state_input_enable;
            next_rdata[apms_pkg::CTRL_TRIG_IN_EN] = trigger_input_enable;
            next_rdata[apms_pkg::CTRL_BACKWARD] = backward;
        end else if (addr == apms_pkg::OFS_STATUS) begin
            next_rdata[apms_pkg::STAT_LOCK] = first_lock_flag;
            next_rdata[apms_pkg::STAT_MODE_SHADOW] = mode_shadow;
            next_rdata[apms_pkg::STAT_MISSING] = missing_state_flag;
            next_rdata[apms_pkg::STAT_GAP_LSB +: 3] = gap_count;
        end else if (addr == apms_pkg::OFS_STATE_STORED) begin
            next_rdata[POS_W-1:0] = state_position_stored;
        end else if (addr == apms_pkg::OFS_TRIG_STORED) begin
            next_rdata[POS_W-1:0] = trigger_position_stored;
        end else if (addr == apms_pkg::OFS_STATE_CORR) begin
            next_rdata[POS_W-1:0] = state_position_corrected;
        end else if (addr == apms_pkg::OFS_TRIG_CORR) begin
            next_rdata[POS_W-1:0] = trigger_position_corrected;
        end else if (addr == apms_pkg::OFS_INC_CNT) begin
            next_rdata[POS_W-1:0] = pulse_increment_count;
        end else if (addr == apms_pkg::OFS_STATE_TARGET) begin
            next_rdata[POS_W-1:0] = state_target;
        end else if (addr == apms_pkg::OFS_TRIG_TARGET) begin
            next_rdata[POS_W-1:0] = trig_target;
        end else if (addr == apms_pkg::OFS_TRIG_TOOTH) begin
            next_rdata[apms_pkg::TOOTH_SYN_LSB +: apms_pkg::SYN_W] = trig_syn;
            next_rdata[apms_pkg::TOOTH_OLD_LSB +: apms_pkg::SYN_W] = trig_syn_old;
        end else if (addr == apms_pkg::OFS_STATE_TOOTH) begin
            next_rdata[apms_pkg::TOOTH_SYN_LSB +: apms_pkg::SYN_W] = state_syn;
            next_rdata[apms_pkg::TOOTH_OLD_LSB +: apms_pkg::SYN_W] = state_syn_old;
        end
    end
    // Read data valid only the cycle after the strobe, zero otherwise
    always_ff @(posedge clock) begin
        if (srst) begin
            rdata <= apms_pkg::RESET_ZERO;
        end else begin
            rdata <= rd ? next_rdata : apms_pkg::RESET_ZERO;
        end
    end
endmodule

/* tb/apms_mode_switch_tb_top.sv */
// Self-checking bench for the angle PLL mode-switch block
`timescale 1ns/1ps
module apms_mode_switch_tb_top;
    localparam int PW = apms_pkg::POS_W;
    logic clock = 1'b0;
    logic srst = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h00000000;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [31:0] rdata;
    logic [3:0] pins = 4'h0;
    logic lock;
    logic [PW-1:0] st_corr;
    logic [PW-1:0] tr_corr;
    logic [PW-1:0] s, t, inc, ts, tt;
    logic [31:0] v, w;
    int n_errors = 0;
    int checked = 0;
    int cycles = 0;

    apms_mode_switch #(.POS_W(PW)) u_dut (.clock(clock), .srst(srst), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .state_slope_pin(pins[0]),
        .trigger_slope_pin(pins[1]), .missing_state_pin(pins[2]),
        .direction_change_pin(pins[3]), .first_lock_flag(lock),
        .state_position_corrected(st_corr), .trigger_position_corrected(tr_corr));

    always #4 clock = ~clock;
    ////////////////////////////////////////////////////////////////////////////////
    // Hang guard: the whole sequence needs well under a thousand cycles
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            n_errors++;
            give_verdict();
        end
    end
    task give_verdict;
        $display("Comparisons %0d, mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task wreg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clock);
        wr <= 1'b0;
    endtask
    // Write then read straight behind it, so both strobes sit on adjacent edges
    task wr_rd(input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        wreg(a, d);
        rd <= 1'b1;
        @(posedge clock);
        rd <= 1'b0;
        #1 q = rdata;
    endtask
    task rreg(input logic [7:0] a, output logic [31:0] q);
        @(posedge clock);
        rd <= 1'b1;
        addr <= a;
        @(posedge clock);
        rd <= 1'b0;
        #1 q = rdata;
    endtask
    // Pin held three cycles, then enough quiet cycles for the synchroniser to settle
    task pulse(input int i);
        @(posedge clock);
        pins[i] <= 1'b1;
        repeat (3) @(posedge clock);
        pins[i] <= 1'b0;
        repeat (7) @(posedge clock);
        #1;
    endtask
    function automatic logic [31:0] ctl(input logic en, input logic em, input logic bk);
        ctl = 32'h00000000;
        ctl[apms_pkg::CTRL_PLL_ENABLE] = en;
        ctl[apms_pkg::CTRL_EMERGENCY] = em;
        ctl[apms_pkg::CTRL_STATE_IN_EN] = 1'b1;
        ctl[apms_pkg::CTRL_TRIG_IN_EN] = 1'b1;
        ctl[apms_pkg::CTRL_BACKWARD] = bk;
    endfunction
    // Stored count moved by increment minus target, sign from direction
    function automatic logic [31:0] corr(input logic [PW-1:0] b, input logic [PW-1:0] tg,
                                         input logic bk);
        corr = {8'h00, bk ? b - (inc - tg) : b + (inc - tg)};
    endfunction
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        v = $urandom(32'h0246);
        repeat (16) @(posedge clock);
        srst <= 1'b0;
        rreg(8'h30, v);
        check(v, 32'h00000000);
        // Direct software writes of corrected counts and tooth registers
        for (int k = 0; k < 4; k++) begin
            v = $urandom & 32'h00FFFFFF;
            wr_rd(k[0] ? apms_pkg::OFS_TRIG_CORR : apms_pkg::OFS_STATE_CORR, v, w);
            check(w, v);
            check({8'h00, k[0] ? tr_corr : st_corr}, v);
            v = 32'h80000000 | ($urandom & 32'h000FFFFF);
            wr_rd(k[0] ? apms_pkg::OFS_TRIG_TOOTH : apms_pkg::OFS_STATE_TOOTH, v, w);
            check(w & 32'h000FFFFF, v & 32'h000FFFFF);
        end
        // Without the sync write bit the trigger tooth fields must not move
        wr_rd(apms_pkg::OFS_TRIG_TOOTH, ~v & 32'h000FFFFF, w);
        check(w & 32'h000FFFFF, v & 32'h000FFFFF);
        s = PW'($urandom);
        t = PW'($urandom);
        inc = PW'($urandom);
        ts = PW'($urandom);
        tt = PW'($urandom);
        wreg(apms_pkg::OFS_STATE_STORED, {8'h00, s});
        wreg(apms_pkg::OFS_TRIG_STORED, {8'h00, t});
        wreg(apms_pkg::OFS_INC_CNT, {8'h00, inc});
        wreg(apms_pkg::OFS_STATE_TARGET, {8'h00, ts});
        wreg(apms_pkg::OFS_TRIG_TARGET, {8'h00, tt});
        // Start in normal mode: first trigger slope copies the stored count
        wreg(apms_pkg::OFS_CTRL, ctl(1'b0, 1'b0, 1'b0));
        wreg(apms_pkg::OFS_CTRL, ctl(1'b1, 1'b0, 1'b0));
        pulse(1);
        check({8'h00, tr_corr}, {8'h00, t});
        // Normal to emergency going forward, correction once only
        wreg(apms_pkg::OFS_CTRL, ctl(1'b1, 1'b1, 1'b0));
        pulse(1);
        pulse(0);
        check({8'h00, st_corr}, corr(s, ts, 1'b0));
        pulse(0);
        check({8'h00, st_corr}, corr(s, ts, 1'b0));
        // Emergency to normal going backward
        wreg(apms_pkg::OFS_CTRL, ctl(1'b1, 1'b0, 1'b1));
        pulse(0);
        pulse(1);
        check({8'h00, tr_corr}, corr(t, tt, 1'b1));
        // Lock lost on direction change, regained after two gaps
        wreg(apms_pkg::OFS_CTRL, ctl(1'b1, 1'b1, 1'b0));
        pulse(1);
        pulse(0);
        check({31'h0, lock}, 32'h00000001);
        pulse(3);
        check({31'h0, lock}, 32'h00000000);
        pulse(2);
        check({31'h0, lock}, 32'h00000000);
        rreg(apms_pkg::OFS_STATUS, v);
        check(v & 32'h00000004, 32'h00000004);
        // Shadow holds emergency, missing flag set, one gap counted, lock low
        check(v & 32'h00000077, 32'h00000016);
        pulse(2);
        check({31'h0, lock}, 32'h00000001);
        // Writing a one to the missing flag clears it
        wreg(apms_pkg::OFS_STATUS, 32'h00000004);
        rreg(apms_pkg::OFS_STATUS, v);
        check(v & 32'h00000004, 32'h00000000);
        // Restart straight into emergency mode: plain copy of stored state count
        wreg(apms_pkg::OFS_CTRL, 32'h00000000);
        s = PW'($urandom);
        wreg(apms_pkg::OFS_STATE_STORED, {8'h00, s});
        wreg(apms_pkg::OFS_CTRL, ctl(1'b0, 1'b1, 1'b0));
        wreg(apms_pkg::OFS_CTRL, ctl(1'b1, 1'b1, 1'b0));
        pulse(0);
        check({8'h00, st_corr}, {8'h00, s});
        // Mode change with no slope after it: software installs the correction
        wreg(apms_pkg::OFS_CTRL, ctl(1'b1, 1'b0, 1'b0));
        wreg(apms_pkg::OFS_TRIG_CORR, corr(t, tt, 1'b0));
        rreg(apms_pkg::OFS_TRIG_CORR, v);
        check(v, corr(t, tt, 1'b0));
        check({8'h00, tr_corr}, corr(t, tt, 1'b0));
        give_verdict();
    end
endmodule

/* tb/apms_monitor.sv */
// Port-level checker for the angle PLL mode-switch block
`timescale 1ns/1ps
module apms_monitor #(
    parameter int POS_W = apms_pkg::POS_W
) (
    input wire logic clock,
    input wire logic srst,
    input wire logic [apms_pkg::ADDR_W-1:0] addr,
    input wire logic [apms_pkg::DATA_W-1:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [apms_pkg::DATA_W-1:0] rdata,
    input wire logic state_slope_pin,
    input wire logic trigger_slope_pin,
    input wire logic missing_state_pin,
    input wire logic direction_change_pin,
    input wire logic first_lock_flag,
    input wire logic [POS_W-1:0] state_position_corrected,
    input wire logic [POS_W-1:0] trigger_position_corrected
);
    logic emg;
    ////////////////////////////////////////////////////////////////////////////////
    // Last written run-in-emergency setting; the shadow itself is not visible here
    always_ff @(posedge clock) begin
        if (srst) begin
            emg <= 1'b0;
        end else if (wr && addr == apms_pkg::OFS_CTRL) begin
            emg <= wdata[apms_pkg::CTRL_EMERGENCY] & wdata[apms_pkg::CTRL_PLL_ENABLE];
        end
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);
    // Sync write to a tooth register, then a read of the same place
    sequence tooth_wr(a);
        wr && addr == a && wdata[apms_pkg::TOOTH_SYNC_WRITE_ENABLE];
    endsequence
    sequence read_of(a);
        rd && !wr && addr == a;
    endsequence
    ////////////////////////////////////////////////////////////////////////////////
    rd_idle_a: assert property (!rd |=> rdata == 32'h00000000)
        else $error("read data not zero outside a read answer");
    unmapped_rd_a: assert property (rd && addr > 8'h28 |=> rdata == 32'h00000000)
        else $error("unmapped read gave data");
    state_wr_a: assert property (wr && addr == apms_pkg::OFS_STATE_CORR
        |=> state_position_corrected == $past(wdata[POS_W-1:0]))
        else $error("corrected state count did not take the write");
    trig_wr_a: assert property (wr && addr == apms_pkg::OFS_TRIG_CORR
        |=> trigger_position_corrected == $past(wdata[POS_W-1:0]))
        else $error("corrected trigger count did not take the write");
    state_hold_a: assert property ((!state_slope_pin)[*7] ##0 !wr
        |=> $stable(state_position_corrected))
        else $error("corrected state count moved without a slope");
    trig_hold_a: assert property ((!trigger_slope_pin)[*7] ##0 !wr
        |=> $stable(trigger_position_corrected))
        else $error("corrected trigger count moved without a slope");
    trig_tooth_a: assert property (tooth_wr(apms_pkg::OFS_TRIG_TOOTH)
        ##1 read_of(apms_pkg::OFS_TRIG_TOOTH) |=> rdata[19:0] == $past(wdata[19:0], 2))
        else $error("trigger tooth fields differ from written bits");
    state_tooth_a: assert property (tooth_wr(apms_pkg::OFS_STATE_TOOTH)
        ##1 read_of(apms_pkg::OFS_STATE_TOOTH) |=> rdata[19:0] == $past(wdata[19:0], 2))
        else $error("state tooth fields differ from written bits");
    lock_drop_a: assert property ($rose(direction_change_pin) && emg
        |-> ##6 !first_lock_flag)
        else $error("lock flag kept after direction change");
endmodule

bind apms_mode_switch apms_monitor #(.POS_W(POS_W)) u_mon (.clock(clock), .srst(srst),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .state_slope_pin(state_slope_pin), .trigger_slope_pin(trigger_slope_pin),
    .missing_state_pin(missing_state_pin), .direction_change_pin(direction_change_pin),
    .first_lock_flag(first_lock_flag), .state_position_corrected(state_position_corrected),
    .trigger_position_corrected(trigger_position_corrected));
